// file: rtl/cpuabs_params.svh
// Summary of operation
// RL1 - Add-with-carry sums working register, file register and carry; updates N, OV, C, DC, Z.
// RL2 - Destination bit 0 writes working register; 1 writes back to the file register.
// RL3 - Access bit 0 uses the access bank; 1 uses the bank select pointer.
// RL4 - Extended set, access bit 0, address up to 5Fh: indexed literal offset addressing.
// RL5 - Branch-on-carry jumps only when carry is 1 and leaves all flags alone.
// RL6 - Taken branch target is current address plus 2 plus twice signed offset.
// RL7 - Branch takes one cycle, or two when taken; the second cycle does nothing.
// RL8 - AND ops update only N and Z; bit clear clears one bit, flags untouched.
`ifndef CPUABS_PARAMS_SVH
`define CPUABS_PARAMS_SVH

`define CPUABS_OPC6_ADDC 6'h08
`define CPUABS_OPC6_ANDF 6'h05
`define CPUABS_OPC8_ANDL 8'h0B
`define CPUABS_OPC8_BRC 8'hE2
`define CPUABS_OPC4_BCLR 4'h9

`define CPUABS_FLD_DEST 9
`define CPUABS_FLD_ACC 8
`define CPUABS_FLD_BIT_HI 11
`define CPUABS_FLD_BIT_LO 9

`define CPUABS_ACC_LIMIT 8'h5F
`define CPUABS_ACC_LO_BANK 4'h0
`define CPUABS_ACC_HI_BANK 4'hF

`define CPUABS_PC_STEP 21'h0_0002
`define CPUABS_PC_RESET 21'h0_0000
`define CPUABS_W_RESET 8'h00
`define CPUABS_INSTR_NOP 16'h0000

`endif

// file: rtl/cpuabs_pkg.sv
package cpuabs_pkg;
  // Instruction cycle phases, Gray coded in order
  typedef enum logic [1:0] {
    CPUABS_Q1 = 2'h0,
    CPUABS_Q2 = 2'h1,
    CPUABS_Q3 = 2'h3,
    CPUABS_Q4 = 2'h2
  } cpuabs_phase_t;
endpackage

// file: rtl/cpuabs_adder8.sv
`timescale 1ns/1ps
module cpuabs_adder8 (
  input wire logic [7:0] op_a, // First addend
  input wire logic [7:0] op_b, // Second addend
  input wire logic cin, // Carry in
  output logic [7:0] sum, // Sum
  output logic cout, // Carry out of bit 7
  output logic dcout, // Carry out of bit 3
  output logic ovf // Signed overflow
);
  logic [4:0] low_sum;
  logic [8:0] full_sum;

  assign low_sum = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, cin};
  assign full_sum = {1'b0, op_a} + {1'b0, op_b} + {8'h00, cin};
  assign sum = full_sum[7:0];
  assign cout = full_sum[8];
  assign dcout = low_sum[4];
  assign ovf = (op_a[7] == op_b[7]) && (full_sum[7] != op_a[7]);
endmodule

// file: rtl/cpuabs_core.sv
`timescale 1ns/1ps
`include "cpuabs_params.svh"
module cpuabs_core (
  input wire logic core_clk, // Core clock, one phase per rising edge
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [15:0] instr_in, // Program word at pc, sampled in Q1
  input wire logic [7:0] mem_rdata, // Data memory read for mem_addr
  input wire logic [3:0] bank_select_pointer, // Bank for access bit 1
  input wire logic ext_set_en, // Extended instruction set enabled
  input wire logic [11:0] index_base, // Base pointer for indexed mode
  output cpuabs_pkg::cpuabs_phase_t phase, // Current phase
  output logic [20:0] pc, // Address of current instruction
  output logic [7:0] w, // Working register
  output logic [11:0] mem_addr, // Data memory address
  output logic [7:0] mem_wdata, // Data memory write data
  output logic mem_we, // Write strobe, high during Q4
  output logic flag_n, // Negative flag
  output logic flag_ov, // Overflow flag
  output logic flag_z, // Zero flag
  output logic flag_dc, // Digit carry flag
  output logic flag_c, // Carry flag
  output logic nop_cycle // Second cycle of a taken branch
);
  import cpuabs_pkg::*;

  cpuabs_phase_t phase_r;
  logic [15:0] instr_r;
  logic [20:0] pc_r;
  logic [7:0] w_r;
  logic [11:0] addr_r;
  logic [7:0] rdata_r;
  logic [7:0] result_r;
  logic we_r;
  logic n_r, ov_r, z_r, dc_r, c_r;
  logic sum_c_r, sum_dc_r, sum_ov_r;
  logic bubble_r;

  // Address decode of the incoming word
  wire [7:0] in_f = instr_in[7:0];
  wire in_acc = instr_in[`CPUABS_FLD_ACC];
  wire in_indexed = ext_set_en && !in_acc && (in_f <= `CPUABS_ACC_LIMIT);
  wire [11:0] acc_addr = (in_f <= `CPUABS_ACC_LIMIT) ? {`CPUABS_ACC_LO_BANK, in_f}
                                                     : {`CPUABS_ACC_HI_BANK, in_f};
  wire [11:0] addr_nxt = in_indexed ? (index_base + {4'h0, in_f}) :
                         in_acc ? {bank_select_pointer, in_f} : acc_addr;

  // Decode of the held word
  wire is_addc = instr_r[15:10] == `CPUABS_OPC6_ADDC;
  wire is_andf = instr_r[15:10] == `CPUABS_OPC6_ANDF;
  wire is_andl = instr_r[15:8] == `CPUABS_OPC8_ANDL;
  wire is_brc = instr_r[15:8] == `CPUABS_OPC8_BRC;
  wire is_bclr = instr_r[15:12] == `CPUABS_OPC4_BCLR;
  wire dest_f = instr_r[`CPUABS_FLD_DEST];
  wire [2:0] bit_sel = instr_r[`CPUABS_FLD_BIT_HI:`CPUABS_FLD_BIT_LO];
  wire writes_f = ((is_addc || is_andf) && dest_f) || is_bclr;
  wire writes_w = ((is_addc || is_andf) && !dest_f) || is_andl;
  wire sets_nz = is_addc || is_andf || is_andl;

  // Data path
  wire [7:0] sum;
  wire sum_c, sum_dc, sum_ov;
  cpuabs_adder8 u_adder (
    .op_a(w_r),
    .op_b(rdata_r),
    .cin(c_r),
    .sum(sum),
    .cout(sum_c),
    .dcout(sum_dc),
    .ovf(sum_ov)
  );
  wire [7:0] bit_mask = 8'h01 << bit_sel;
  wire [7:0] result_nxt = is_addc ? sum : // RL1
                          is_andl ? (w_r & instr_r[7:0]) : // RL8
                          is_andf ? (w_r & rdata_r) : // RL8
                          (rdata_r & ~bit_mask); // RL8
  wire taken = is_brc && c_r; // RL5
  wire [20:0] br_off = {{12{instr_r[7]}}, instr_r[7:0], 1'b0};
  wire [20:0] pc_seq = pc_r + `CPUABS_PC_STEP;
  wire [20:0] pc_nxt = bubble_r ? pc_r : taken ? (pc_seq + br_off) : pc_seq; // RL6

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      phase_r <= CPUABS_Q1;
    end else begin
      unique case (phase_r)
        CPUABS_Q1: phase_r <= CPUABS_Q2;
        CPUABS_Q2: phase_r <= CPUABS_Q3;
        CPUABS_Q3: phase_r <= CPUABS_Q4;
        CPUABS_Q4: phase_r <= CPUABS_Q1;
      endcase
    end
  end

  // Q1 decode, Q2 read
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      instr_r <= `CPUABS_INSTR_NOP;
      addr_r <= 12'h000;
      rdata_r <= 8'h00;
    end else begin
      if (phase_r == CPUABS_Q1) begin
        instr_r <= bubble_r ? `CPUABS_INSTR_NOP : instr_in; // RL7
        addr_r <= addr_nxt; // RL3 RL4
      end
      if (phase_r == CPUABS_Q2) begin
        rdata_r <= mem_rdata;
      end
    end
  end

  // Q3 process
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      result_r <= 8'h00;
      we_r <= 1'b0;
      sum_c_r <= 1'b0;
      sum_dc_r <= 1'b0;
      sum_ov_r <= 1'b0;
    end else if (phase_r == CPUABS_Q3) begin
      result_r <= result_nxt;
      we_r <= writes_f; // RL2
      sum_c_r <= sum_c;
      sum_dc_r <= sum_dc;
      sum_ov_r <= sum_ov;
    end else if (phase_r == CPUABS_Q4) begin
      we_r <= 1'b0;
    end
  end

  // Q4 write back
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pc_r <= `CPUABS_PC_RESET;
      w_r <= `CPUABS_W_RESET;
      bubble_r <= 1'b0;
      {n_r, ov_r, z_r, dc_r, c_r} <= 5'h00;
    end else if (phase_r == CPUABS_Q4) begin
      pc_r <= pc_nxt; // RL6
      bubble_r <= taken && !bubble_r; // RL7
      if (writes_w) begin
        w_r <= result_r; // RL2
      end
      if (sets_nz) begin
        n_r <= result_r[7]; // RL8
        z_r <= result_r == 8'h00;
      end
      if (is_addc) begin
        c_r <= sum_c_r; // RL1
        dc_r <= sum_dc_r;
        ov_r <= sum_ov_r;
      end
    end
  end

  assign phase = phase_r;
  assign pc = pc_r;
  assign w = w_r;
  assign mem_addr = addr_r;
  assign mem_wdata = result_r;
  assign mem_we = we_r;
  assign flag_n = n_r;
  assign flag_ov = ov_r;
  assign flag_z = z_r;
  assign flag_dc = dc_r;
  assign flag_c = c_r;
  assign nop_cycle = bubble_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_q3_of(op);
    phase_r == CPUABS_Q3 && op;
  endsequence

  // Pc already holds the target in the first phase, so stability starts one phase later
  sequence s_bubble_cycle;
    (bubble_r && !mem_we) ##1
      (bubble_r && !mem_we && $stable(pc_r) && $stable(w_r)) [*3];
  endsequence

  a_addc_sum: assert property ( // RL1
    s_q3_of(is_addc) |=>
      {sum_c_r, result_r} == ({1'b0, $past(w_r)} + {1'b0, $past(rdata_r)} + {8'h00, $past(c_r)}))
    else $error("add with carry result wrong");

  a_dest_w: assert property ( // RL2
    s_q3_of(writes_w) |=> ##1 (w_r == $past(result_r) && !mem_we))
    else $error("working register not written");

  a_dest_file: assert property ( // RL2
    s_q3_of(writes_f) |=> (mem_we && mem_wdata == $past(result_nxt)) ##1 !mem_we)
    else $error("file write missing");

  a_bank_addr: assert property ( // RL3
    (phase_r == CPUABS_Q1 && instr_in[8]) |=>
      mem_addr == {$past(bank_select_pointer), $past(instr_in[7:0])})
    else $error("banked address wrong");

  a_indexed_addr: assert property ( // RL4
    (phase_r == CPUABS_Q1 && ext_set_en && !instr_in[8] && instr_in[7:0] <= 8'h5F) |=>
      mem_addr == 12'($past(index_base) + {4'h0, $past(instr_in[7:0])}))
    else $error("indexed address wrong");

  a_brc_flags: assert property ( // RL5
    (phase_r == CPUABS_Q4 && is_brc) |=> $stable({n_r, ov_r, z_r, dc_r, c_r}))
    else $error("branch changed flags");

  a_brc_target: assert property ( // RL6
    (phase_r == CPUABS_Q4 && is_brc && c_r && !bubble_r) |=>
      pc_r == 21'($past(pc_r) + 21'h0_0002 + {{12{$past(instr_r[7])}}, $past(instr_r[7:0]), 1'b0}))
    else $error("branch target wrong");

  a_brc_untaken: assert property ( // RL5
    (phase_r == CPUABS_Q4 && is_brc && !c_r && !bubble_r) |=>
      (pc_r == 21'($past(pc_r) + 21'h0_0002) && !bubble_r))
    else $error("untaken branch moved wrongly");

  a_bubble_idle: assert property ( // RL7
    (phase_r == CPUABS_Q4 && taken && !bubble_r) |=>
      s_bubble_cycle ##1 !bubble_r)
    else $error("taken branch second cycle not idle");

  a_and_flags: assert property ( // RL8
    (phase_r == CPUABS_Q4 && (is_andf || is_andl || is_bclr)) |=>
      $stable({ov_r, dc_r, c_r}))
    else $error("logic op touched arithmetic flags");
endmodule

// file: tb/tb.sv
`timescale 1ns/1ps
`include "cpuabs_params.svh"
module tb;
  import cpuabs_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] instr_in = `CPUABS_INSTR_NOP;
  logic [7:0] mem_rdata = 8'h00;
  logic [3:0] bank_select_pointer = 4'hA;
  logic ext_set_en = 1'b0;
  logic [11:0] index_base = 12'h3C0;
  cpuabs_phase_t phase;
  logic [20:0] pc, rpc, tgt;
  logic [20:0] mpc = 21'h0_0000;
  logic [7:0] w, mem_wdata, mwd, rw, s;
  logic [7:0] mw = 8'h00;
  logic [11:0] mem_addr, mad;
  logic [4:0] rf;
  logic mem_we, flag_n, flag_ov, flag_z, flag_dc, flag_c, nop_cycle, mwe, rnop;
  logic mn = 1'b0, mov = 1'b0, mz = 1'b0, mdc = 1'b0, mc = 1'b0;
  int failures = 0;
  int check_count = 0;

  cpuabs_core uut (.core_clk, .rst_n, .instr_in, .mem_rdata, .bank_select_pointer,
    .ext_set_en, .index_base, .phase, .pc, .w, .mem_addr, .mem_wdata, .mem_we,
    .flag_n, .flag_ov, .flag_z, .flag_dc, .flag_c, .nop_cycle);

  always #20 core_clk = ~core_clk;

  task cmp(input logic [20:0] got, input logic [20:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One instruction, then a filler cycle whose Q1 shows the results
  task exec(input logic [15:0] i, input logic [7:0] r);
    instr_in <= i;
    mem_rdata <= r;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    mwe = mem_we;
    mwd = mem_wdata;
    mad = mem_addr;
    @(posedge core_clk);
    instr_in <= `CPUABS_INSTR_NOP;
    @(negedge core_clk);
    rw = w;
    rf = {flag_n, flag_ov, flag_z, flag_dc, flag_c};
    rpc = pc;
    rnop = nop_cycle;
    repeat (4) @(posedge core_clk);
  endtask

  task post(input logic we, input logic [7:0] wd);
    cmp(mwe, we);
    if (we) cmp(mwd, wd);
    cmp(rw, mw);
    cmp(rf, {mn, mov, mz, mdc, mc});
    cmp(rpc, mpc + 21'h0_0002);
    mpc = mpc + 21'h0_0004;
  endtask

  task t_add(input logic d, input logic [7:0] r);
    logic [8:0] t;
    logic [4:0] h;
    t = {1'b0, mw} + {1'b0, r} + {8'h00, mc};
    h = {1'b0, mw[3:0]} + {1'b0, r[3:0]} + {4'h0, mc};
    exec({`CPUABS_OPC6_ADDC, d, 1'b1, 8'h33}, r);
    cmp(mad, 12'hA33);
    mov = (mw[7] == r[7]) && (t[7] != mw[7]);
    {mc, mdc, mn, mz} = {t[8], h[4], t[7], t[7:0] == 8'h00};
    if (!d) mw = t[7:0];
    post(d, t[7:0]);
  endtask

  task t_and(input logic lit, input logic d, input logic [7:0] r);
    exec(lit ? {`CPUABS_OPC8_ANDL, r} : {`CPUABS_OPC6_ANDF, d, 1'b1, 8'h44}, r);
    s = mw & r;
    {mn, mz} = {s[7], s == 8'h00};
    if (!d) mw = s;
    post(d, s);
  endtask

  task t_br(input logic [7:0] n);
    tgt = mpc + 21'h0_0002 + {{12{n[7]}}, n, 1'b0};
    exec({`CPUABS_OPC8_BRC, n}, 8'h00);
    cmp(rnop, mc);
    cmp(mwe, 1'b0);
    cmp(rw, mw);
    cmp(rf, {mn, mov, mz, mdc, mc});
    cmp(rpc, mc ? tgt : mpc + 21'h0_0002);
    mpc = mc ? tgt : mpc + 21'h0_0004;
  endtask

  task t_clr(input logic x, input logic a, input logic [2:0] b, input logic [7:0] f,
    input logic [7:0] r, input logic [11:0] ea);
    ext_set_en <= x;
    exec({`CPUABS_OPC4_BCLR, b, a, f}, r);
    cmp(mad, ea);
    post(1'b1, r & ~(8'h01 << b));
  endtask

  task final_report;
    $display("checks=%0d mismatches=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    final_report;
  end

  initial begin
    repeat (15) @(posedge core_clk);
    @(negedge core_clk);
    cmp(pc, `CPUABS_PC_RESET);
    cmp(w, `CPUABS_W_RESET);
    cmp({flag_n, flag_ov, flag_z, flag_dc, flag_c}, 5'h00);
    cmp({mem_we, nop_cycle}, 2'h0);
    cmp(mem_addr, 12'h000);
    cmp(mem_wdata, 8'h00);
    cmp(phase, CPUABS_Q1);
    @(posedge core_clk);
    rst_n <= 1'b1;
    $display("test reset done");
    t_add(1'b0, 8'h4D);
    t_add(1'b0, 8'hFF);
    t_add(1'b1, 8'h02);
    t_add(1'b0, 8'h34);
    t_add(1'b0, 8'h80);
    $display("test add done");
    t_br(8'h05);
    t_br(8'h80);
    t_add(1'b0, 8'h00);
    t_br(8'h7F);
    $display("test branch done");
    t_and(1'b1, 1'b0, 8'h5F);
    t_add(1'b0, 8'hA2);
    t_and(1'b1, 1'b0, 8'h5F);
    t_and(1'b0, 1'b0, 8'hC2);
    t_and(1'b0, 1'b1, 8'h00);
    $display("test and done");
    t_clr(1'b0, 1'b1, 3'h7, 8'h33, 8'hC7, 12'hA33);
    t_clr(1'b0, 1'b0, 3'h0, 8'h5F, 8'hFF, 12'h05F);
    t_clr(1'b0, 1'b0, 3'h3, 8'h60, 8'h0F, 12'hF60);
    t_clr(1'b1, 1'b0, 3'h5, 8'h5F, 8'hFF, 12'h41F);
    t_clr(1'b1, 1'b0, 3'h1, 8'h60, 8'h02, 12'hF60);
    t_clr(1'b1, 1'b1, 3'h2, 8'h10, 8'h04, 12'hA10);
    $display("test clear done");
    final_report;
  end
endmodule
